// ---- rssm_consts.svh ----
`ifndef RSSM_CONSTS_SVH
`define RSSM_CONSTS_SVH

// register offsets on the special function register port
`define RSSM_SMC_ADDR        8'hFF
`define RSSM_RCR_ADDR        8'hEF
// supply monitor control fields
`define RSSM_SMC_EN_BIT      7
`define RSSM_SMC_STAT_BIT    6
// reset cause register fields
`define RSSM_RCR_PIN_BIT     0
`define RSSM_RCR_POR_BIT     1
// reset values
`define RSSM_PORT_RST        8'hFF
`define RSSM_PC_RST          16'h0000
`define RSSM_WDT_DIV         12
// cycles the pin echo takes through the synchroniser and pin register
`define RSSM_PIN_QUIET       2'h3
// power-on hold delay, ns, and clock period, ns
`define RSSM_POR_DELAY_NS    300000
`define RSSM_CLK_NS          5

`endif

// ---- rssm_pkg.sv ----
package rssm_pkg;

	typedef enum logic [1:0] {
		RSSM_POWER_UP,
		RSSM_HOLD,
		RSSM_RUN
	} rssm_state_t;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rssm_sfr_req_t;

	typedef struct packed {
		logic       por;
		logic       pin;
		logic       supply;
	} rssm_cause_t;

endpackage

// ---- rssm_sync.sv ----
`timescale 1ns/1ps

module rssm_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			stage1 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end

endmodule

// ---- rssm_wdt_div.sv ----
`timescale 1ns/1ps
`include "rssm_consts.svh"

module rssm_wdt_div #(
	parameter int DIV = `RSSM_WDT_DIV
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// core held in reset restarts the divider
	input  wire logic i_hold,
	// one-cycle watchdog tick
	output logic      o_tick
);

	localparam int CW = $clog2(DIV);

	logic [CW-1:0] count;
	wire           wrap = (count == CW'(DIV - 1));

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count  <= '0;
			o_tick <= 1'b0;
		end else if (i_hold) begin
			count  <= '0;
			o_tick <= 1'b0;
		end else begin
			count  <= wrap ? '0 : CW'(count + 1'b1);
			o_tick <= wrap;
		end
	end

endmodule

// ---- rssm_top.sv ----
// What this block does
// - reset halts core, loads registers, disables timers
// - data memory untouched by any reset
// - port latches all ones, open drain, pullups
// - drive reset pin low for power, supply
// - on exit reset pc, internal oscillator
// - fetching starts at address zero
// - watchdog enabled, clocked at clock over twelve
// - power-up holds until trip, then delay
// - power-on exit sets power-on cause flag
// - other resets clear power-on cause flag
// - data memory undefined after power-on
// - power-on disables monitor, others keep it
// - supply low holds reset until recovery
// - supply monitor release adds no delay
// - writing power-on flag selects supply monitor
// - control: enable bit7, status bit6, reserved
`timescale 1ns/1ps
`include "rssm_consts.svh"

module rssm_top #(
	parameter int POR_DELAY_NS = `RSSM_POR_DELAY_NS,
	parameter int CLK_NS       = `RSSM_CLK_NS
) (
	// clock and power-up reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// analog and pin inputs, asynchronous
	input  wire logic                   i_supply_above_trip,
	input  wire logic                   i_reset_pin_n,
	// special function register port
	input  wire rssm_pkg::rssm_sfr_req_t i_sfr,
	output logic [7:0]                  o_sfr_rdata,
	// reset pin, open drain; enable low drives it low
	output logic                        o_reset_pin_o,
	output logic                        o_reset_pin_oe_n,
	// core control
	output logic                        o_core_rst,
	output logic [15:0]                 o_pc_start,
	output logic                        o_use_int_osc,
	output logic [7:0]                  o_port_latch,
	output logic                        o_port_open_drain,
	output logic                        o_weak_pullup,
	output logic                        o_irq_timer_enable,
	output logic                        o_wdt_enable,
	output logic                        o_wdt_tick
);

	localparam int POR_CYC_RAW = POR_DELAY_NS / CLK_NS;
	localparam int POR_CYC     = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
	localparam int PCW         = $clog2(POR_CYC + 1);

	// synchronised external levels
	logic        supply_ok;
	logic        pin_n;
	rssm_sync #(
		.WIDTH (2)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_supply_above_trip, i_reset_pin_n}),
		.o_sync  ({supply_ok, pin_n})
	);

	// state
	rssm_pkg::rssm_state_t state;
	rssm_pkg::rssm_state_t next_state;
	logic [PCW-1:0]        por_count;
	logic                  monitor_en;
	logic                  monitor_sel;
	rssm_pkg::rssm_cause_t cause;
	rssm_pkg::rssm_cause_t pending;
	logic                  core_rst;
	logic [1:0]            pin_quiet;

	// the block pulls the pin low itself; that low comes back through
	// the synchroniser and must not read as a pin reset, or every
	// power-on and supply release would be stretched and blamed on it
	wire pin_echo = (pin_quiet != 2'h0);

	// reset request decode
	wire supply_req = monitor_en & monitor_sel & ~supply_ok;
	wire pin_req    = ~pin_n & ~pin_echo;
	wire run_req    = supply_req | pin_req;
	wire por_done   = (por_count == PCW'(POR_CYC));

	// address match, shared by both register selects
	function automatic logic addr_hit(input logic [7:0] addr,
	                                  input logic [7:0] target);
		return addr == target;
	endfunction

	// register decode
	wire sel_smc  = addr_hit(i_sfr.addr, `RSSM_SMC_ADDR);
	wire sel_rcr  = addr_hit(i_sfr.addr, `RSSM_RCR_ADDR);
	wire wr_smc   = i_sfr.write & sel_smc & ~core_rst;
	wire wr_rcr   = i_sfr.write & sel_rcr & ~core_rst;
	wire [7:0] smc_val = {monitor_en, supply_ok, 6'h00};
	wire [7:0] rcr_val = {6'h00, cause.por, cause.pin};
	wire [7:0] next_rdata = !i_sfr.read ? 8'h00 :
	                        sel_smc     ? smc_val :
	                        sel_rcr     ? rcr_val : 8'h00;

	always_comb begin
		next_state = state;
		case (state)
			rssm_pkg::RSSM_POWER_UP: begin
				if (supply_ok) begin
					next_state = rssm_pkg::RSSM_HOLD;
				end
			end
			rssm_pkg::RSSM_HOLD: begin
				if (por_done) begin
					next_state = rssm_pkg::RSSM_RUN;
				end
			end
			rssm_pkg::RSSM_RUN: begin
				next_state = rssm_pkg::RSSM_RUN;
			end
			default: begin
				next_state = rssm_pkg::RSSM_POWER_UP;
			end
		endcase
	end

	wire in_por      = (state != rssm_pkg::RSSM_RUN);
	wire next_rst    = in_por | run_req;
	wire release_now = core_rst & ~next_rst;
	// the pin only drives for power-on and supply resets
	wire drive_pin   = in_por | supply_req;

	// echo window: held while the pin is driven, then counts out the
	// synchroniser delay before the pin is believed again
	wire [1:0] next_pin_quiet = drive_pin ? `RSSM_PIN_QUIET :
	                            pin_echo  ? pin_quiet - 2'h1 : 2'h0;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_quiet <= `RSSM_PIN_QUIET;
		end else begin
			pin_quiet <= next_pin_quiet;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= rssm_pkg::RSSM_POWER_UP;
		end else begin
			state <= next_state;
		end
	end

	// power-on hold counter runs only in the hold state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			por_count <= '0;
		end else if (state == rssm_pkg::RSSM_HOLD && !por_done) begin
			por_count <= PCW'(por_count + 1'b1);
		end
	end

	// monitor enable: power-on clears it, other resets keep it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			monitor_en <= 1'b0;
		end else if (in_por) begin
			monitor_en <= 1'b0;
		end else if (wr_smc) begin
			monitor_en <= i_sfr.wdata[`RSSM_SMC_EN_BIT];
		end
	end

	// supply monitor chosen as a reset source in the cause register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			monitor_sel <= 1'b0;
		end else if (in_por) begin
			monitor_sel <= 1'b0;
		end else if (wr_rcr) begin
			monitor_sel <= i_sfr.wdata[`RSSM_RCR_POR_BIT];
		end
	end

	// causes are gathered while the core is held
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pending <= '0;
		end else if (next_rst) begin
			pending.por    <= pending.por | in_por;
			pending.pin    <= pending.pin | pin_req;
			pending.supply <= pending.supply | supply_req;
		end else if (core_rst) begin
			pending <= '0;
		end
	end

	// and recorded at the edge that releases the core
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cause <= '0;
		end else if (release_now) begin
			cause <= pending;
			if (!pending.por) begin
				cause.por <= 1'b0;
			end else begin
				cause.por <= 1'b1;
			end
		end
	end

	wire wdt_hold;
	assign wdt_hold = core_rst;

	rssm_wdt_div #(
		.DIV (`RSSM_WDT_DIV)
	) u_wdt (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_hold (wdt_hold),
		.o_tick (o_wdt_tick)
	);

	// core reset; the release is registered, so deassertion is
	// synchronous to the clock
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			core_rst   <= 1'b1;
			o_core_rst <= 1'b1;
		end else begin
			core_rst   <= next_rst;
			o_core_rst <= next_rst;
		end
	end

	// read data stands for the one cycle after a read strobe and is
	// zero otherwise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sfr_rdata <= 8'h00;
		end else begin
			o_sfr_rdata <= next_rdata;
		end
	end

	// the reset pin is open drain and only ever pulls low
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reset_pin_o    <= 1'b0;
			o_reset_pin_oe_n <= 1'b0;
		end else begin
			o_reset_pin_o    <= 1'b0;
			o_reset_pin_oe_n <= ~drive_pin;
		end
	end

	// start address and pullups do not depend on the reset cause
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pc_start    <= `RSSM_PC_RST;
			o_weak_pullup <= 1'b1;
		end else begin
			o_pc_start    <= `RSSM_PC_RST;
			o_weak_pullup <= 1'b1;
		end
	end

	// ports and clock source are forced while held; the core takes
	// them over once it runs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_use_int_osc     <= 1'b1;
			o_port_latch      <= `RSSM_PORT_RST;
			o_port_open_drain <= 1'b1;
		end else if (next_rst) begin
			o_use_int_osc     <= 1'b1;
			o_port_latch      <= `RSSM_PORT_RST;
			o_port_open_drain <= 1'b1;
		end
	end

	// timers stay off until release; the watchdog is on from the
	// first reset cycle, so it is never seen disabled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq_timer_enable <= 1'b0;
			o_wdt_enable       <= 1'b1;
		end else if (next_rst) begin
			o_irq_timer_enable <= 1'b0;
			o_wdt_enable       <= 1'b1;
		end else if (release_now) begin
			o_irq_timer_enable <= 1'b1;
		end
	end

	// no memory is touched here, so data memory is preserved
	// after power-on software must treat memory as undefined
	// software enables the monitor and waits before selecting
	// turn-on wait before selection is software's duty
	// supply release goes straight to run with no hold delay

endmodule

// ---- rssm_top_sva.sv ----
`timescale 1ns/1ps
module rssm_top_sva #(
	parameter int POR_DELAY_NS = 300000,
	parameter int CLK_NS       = 5
) (
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	input wire logic                   i_supply_above_trip,
	input wire logic                   i_reset_pin_n,
	input wire rssm_pkg::rssm_sfr_req_t i_sfr,
	input wire logic [7:0]             o_sfr_rdata,
	input wire logic                   o_reset_pin_o,
	input wire logic                   o_reset_pin_oe_n,
	input wire logic                   o_core_rst,
	input wire logic [15:0]            o_pc_start,
	input wire logic                   o_use_int_osc,
	input wire logic [7:0]             o_port_latch,
	input wire logic                   o_port_open_drain,
	input wire logic                   o_weak_pullup,
	input wire logic                   o_irq_timer_enable,
	input wire logic                   o_wdt_enable,
	input wire logic                   o_wdt_tick
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence tick_gap_s;
		(!o_wdt_tick)[*8];
	endsequence
	chk_pc_zero: assert property (o_pc_start == 16'h0000)
		else $error("start address not zero");
	chk_port_latch: assert property (o_core_rst |->
		o_port_latch == 8'hFF && o_port_open_drain)
		else $error("port latch not all ones in reset");
	chk_pullup_on: assert property (o_weak_pullup)
		else $error("weak pullup off");
	chk_timer_off: assert property (o_core_rst |-> !o_irq_timer_enable)
		else $error("timers enabled in reset");
	chk_int_osc: assert property (o_core_rst |-> o_use_int_osc)
		else $error("internal oscillator not selected");
	chk_wdt_on: assert property (o_wdt_enable)
		else $error("watchdog disabled");
	chk_wdt_spacing: assert property (o_wdt_tick |=> tick_gap_s)
		else $error("watchdog ticks too close");
	chk_pin_drive: assert property (!o_reset_pin_oe_n |->
		o_core_rst && !o_reset_pin_o)
		else $error("reset pin driven outside reset");
	chk_pin_reset: assert property ((!i_reset_pin_n)[*4] |-> o_core_rst)
		else $error("pin reset not taken");
	chk_rdata_idle: assert property (!i_sfr.read |=> o_sfr_rdata == 8'h00)
		else $error("read data without read");
	chk_smc_reserved: assert property (i_sfr.read && i_sfr.addr == 8'hFF
		|=> o_sfr_rdata[5:0] == 6'h00)
		else $error("reserved bits not zero");
endmodule

bind rssm_top rssm_top_sva #(
	.POR_DELAY_NS(POR_DELAY_NS),
	.CLK_NS(CLK_NS)
) chk (.*);

// ---- rssm_far_side.sv ----
`timescale 1ns/1ps
module rssm_far_side (
	// test commands
	input  wire logic i_drop,
	input  wire logic i_pin,
	// device side of the reset pin
	input  wire logic i_oe_n,
	input  wire logic i_drv,
	// comparator and pin level
	output logic      o_supply_ok,
	output logic      o_pin_n
);
	assign o_supply_ok = !i_drop;
	// pulled-up wire, low when either party pulls it
	assign o_pin_n = !i_pin && (i_oe_n || i_drv);
endmodule

// ---- reset_source_and_supply_monitor_tb.sv ----
`timescale 1ns/1ps
module reset_source_and_supply_monitor_tb;
	typedef struct {logic w; logic [7:0] a, d, m, e;} rssm_row_t;
	logic clk = 1'h0, rst = 1'h1, drop = 1'h1, pin = 1'h0;
	rssm_pkg::rssm_sfr_req_t req = '0;
	wire  sup, pin_n, po, oe_n, crst;
	wire  [7:0] rd;
	int   fails = 0, num_checks = 0, n;
	rssm_row_t rows[5] = '{'{0, 8'hFF, 8'h00, 8'hFF, 8'h40},
		'{0, 8'hEF, 8'h00, 8'h02, 8'h02}, '{1, 8'hFF, 8'hBF, 8'h00, 8'h00},
		'{0, 8'hFF, 8'h00, 8'hFF, 8'hC0}, '{0, 8'h10, 8'h00, 8'hFF, 8'h00}};
	always #2.5 clk = ~clk;
	rssm_top #(.POR_DELAY_NS(50)) uut (.i_clk(clk), .i_rst(rst),
		.i_supply_above_trip(sup), .i_reset_pin_n(pin_n), .i_sfr(req),
		.o_sfr_rdata(rd), .o_reset_pin_o(po), .o_reset_pin_oe_n(oe_n),
		.o_core_rst(crst), .o_pc_start(), .o_use_int_osc(),
		.o_port_latch(), .o_port_open_drain(), .o_weak_pullup(),
		.o_irq_timer_enable(), .o_wdt_enable(), .o_wdt_tick());
	rssm_far_side far (.i_drop(drop), .i_pin(pin), .i_oe_n(oe_n),
		.i_drv(po), .o_supply_ok(sup), .o_pin_n(pin_n));
	task report_and_stop();
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task cmp(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task special_function_register(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{w, !w, a, d};
		@(negedge clk);
		req = '0;
	endtask
	task wait_core(input logic v);
		n = 0;
		while (crst !== v && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n == 300) begin
			fails++;
			report_and_stop();
		end
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'h0;
		repeat (20) @(negedge clk);
		cmp(crst, 1'h1);
		cmp(oe_n, 1'h0);
		drop = 1'h0;
		wait_core(1'h0);
		cmp(n >= 13 && n <= 15, 1'h1);
		foreach (rows[i]) begin
			special_function_register(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) cmp(rd & rows[i].m, rows[i].e);
		end
		$display("register test done");
		repeat (8) @(negedge clk);
		special_function_register(1'h1, 8'hEF, 8'h02);
		drop = 1'h1;
		wait_core(1'h1);
		cmp(n <= 4, 1'h1);
		cmp(oe_n, 1'h0);
		drop = 1'h0;
		wait_core(1'h0);
		cmp(n <= 4, 1'h1);
		special_function_register(1'h0, 8'hEF, 8'h00);
		cmp(rd, 8'h00);
		special_function_register(1'h0, 8'hFF, 8'h00);
		cmp(rd, 8'hC0);
		$display("supply reset test done");
		pin = 1'h1;
		repeat (6) @(negedge clk);
		cmp(crst, 1'h1);
		cmp(oe_n, 1'h1);
		pin = 1'h0;
		wait_core(1'h0);
		special_function_register(1'h0, 8'hEF, 8'h00);
		cmp(rd, 8'h01);
		special_function_register(1'h0, 8'hFF, 8'h00);
		cmp(rd, 8'hC0);
		$display("pin reset test done");
		rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		wait_core(1'h0);
		special_function_register(1'h0, 8'hFF, 8'h00);
		cmp(rd, 8'h40);
		special_function_register(1'h0, 8'hEF, 8'h00);
		cmp(rd[1], 1'h1);
		$display("power-on repeat test done");
		report_and_stop();
	end
endmodule
